/* verilog/dcbs_pkg.sv */
// Package with shared constants and types for the dual processor bus share block.
package dcbs_pkg;

    // ------------------------------------------------------------
    // Data cache line states.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DCBS_INVALID,
        DCBS_SHARED,
        DCBS_EXCLUSIVE,
        DCBS_MODIFIED
    } dcbs_mesi_e;

    // ------------------------------------------------------------
    // Geometry and strap polarity.
    // ------------------------------------------------------------
    localparam int DCBS_LINES = 16;          // Default number of tracked lines.
    localparam int DCBS_TAG_W = 28;          // Default line address width.
    localparam logic STRAP_PRIMARY = 1'b0;   // Strap low selects the primary role.

endpackage

/* verilog/dcbs_share_snoop.sv */
// Bus ownership arbitration and peer snoop logic for one processor of a pair.
`timescale 1ns/1ns

module dcbs_share_snoop
    import dcbs_pkg::*;
#(
    parameter int LINES = DCBS_LINES,     // Tracked data cache lines.
    parameter int TAG_W = DCBS_TAG_W      // Line address width.
) (
    input wire logic clk_sys,                 // Common bus clock, 125 MHz.
    input wire logic resetn,                  // Synchronous active-low reset.
    input wire logic role_select_strap,       // Role strap, low or floating is primary.
    input wire logic peer_present,            // Peer detected at boot (primary only).
    input wire logic core_req,                // Core wants a bus cycle.
    input wire logic [TAG_W-1:0] core_addr,   // Line address of the core's cycle.
    input wire logic core_write,              // Core cycle is a write.
    input wire logic core_fill,               // Core cycle is a cacheable line fill.
    input wire logic bus_done,                // Last transfer of the bus cycle.
    input wire logic bus_data_valid,          // Read data beat returned by the system.
    input wire logic [TAG_W-1:0] snoop_addr,  // Address seen on the shared bus.
    input wire logic address_strobe_in,       // Peer's address strobe seen on the bus.
    input wire logic write_read_in,           // Write flag seen with the strobe.
    input wire logic peer_req,                // Peer asks this side for the bus.
    input wire logic peer_grant,              // Peer grants the bus to this side.
    input wire logic peer_hit,                // Peer reports a snoop hit.
    input wire logic peer_hit_mod,            // Peer reports a modified snoop hit.
    input wire logic fill_line_valid,         // Core installs a line into the cache.
    input wire logic [TAG_W-1:0] fill_tag,    // Line address being installed.
    input wire logic fill_dirty,              // Installed line is written by core.
    output logic address_strobe,              // This side starts a bus cycle.
    output logic [TAG_W-1:0] bus_addr,        // Address driven for the cycle.
    output logic bus_write,                   // Cycle is a write.
    output logic bus_wb,                      // Cycle is a line writeback.
    output logic req_out,                     // Request for the bus to the peer.
    output logic grant_out,                   // Grant of the bus to the peer.
    output logic hit_out,                     // Snoop hit reported to the peer.
    output logic hit_mod_out,                 // Modified snoop hit reported to the peer.
    output logic data_drop,                   // Returned data must be discarded.
    output logic rerun,                       // Core must re-issue its cycle.
    output logic core_ack,                    // Core cycle completed with good data.
    output logic is_owner,                    // This side is current_bus_owner.
    output logic is_primary,                  // Role latched from the strap.
    output logic pair_enabled                 // Arbitration and coherency active.
);

    // ------------------------------------------------------------
    // Local types and state.
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCBS_IDLE,
        DCBS_ISSUE,
        DCBS_WAIT,
        DCBS_WB_WAIT,
        DCBS_WB_RUN
    } dcbs_bus_e;

    localparam int IDX_W = $clog2(LINES);

    dcbs_bus_e state;                          // Bus sequencer state.
    dcbs_mesi_e line_state [LINES];            // Data line states.
    logic [TAG_W-1:0] line_tag [LINES];        // Data line tags.
    logic [IDX_W-1:0] next_fill_idx;           // Round-robin fill slot.
    logic [IDX_W-1:0] hit_idx;                 // Slot matching the snoop address.
    logic snoop_match;                         // Snoop address hits a valid line.
    logic snoop_now;                           // Snoop event this cycle.
    logic wb_pending;                          // Writeback owed after a modified hit.
    logic [TAG_W-1:0] wb_addr;                 // Address of the owed writeback.
    logic drop_cur;                            // Current cycle's data is discarded.
    logic peer_req_seen;                       // Peer request outstanding.
    logic outstanding;                         // Own cycle still on the bus.
    logic give_bus;                            // Grant condition this cycle.
    logic want_bus;                            // This side needs the bus.

    // ------------------------------------------------------------
    // Role strap capture.
    // ------------------------------------------------------------
    // The strap is caught by a clocked process during reset; is_owner also takes it as its reset value.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            is_primary <= (role_select_strap == STRAP_PRIMARY);
        end
    end

    // Only the primary detects the peer; the secondary exists only when a primary does.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pair_enabled <= 1'b0;
        end else begin
            pair_enabled <= peer_present | ~is_primary;
        end
    end

    // ------------------------------------------------------------
    // Ownership.
    // ------------------------------------------------------------
    assign outstanding = (state == DCBS_WAIT) || (state == DCBS_WB_RUN);
    // Grant once nothing of ours is still on the bus and no core cycle waits in DCBS_ISSUE.
    assign give_bus = is_owner && pair_enabled && peer_req_seen && !outstanding
                      && state != DCBS_ISSUE;
    assign grant_out = give_bus;
    assign want_bus = (state == DCBS_ISSUE) || (state == DCBS_WB_WAIT);
    // The request rises with a modified hit, in the same cycle.
    // In the grant cycle the roles are already swapping, so a hit there also requests.
    assign req_out = pair_enabled && (!is_owner || give_bus)
                     && (want_bus || hit_mod_out);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            peer_req_seen <= 1'b0;
        end else begin
            peer_req_seen <= peer_req;
        end
    end

    // Ownership swaps in one step on a grant in either direction.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            is_owner <= (role_select_strap == STRAP_PRIMARY);
        end else if (!pair_enabled && is_primary) begin
            // A primary without an enabled peer keeps the bus rather than waiting for a grant.
            is_owner <= 1'b1;
        end else if (give_bus) begin
            is_owner <= 1'b0;
        end else if (peer_grant) begin
            is_owner <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus sequencer.
    // ------------------------------------------------------------
    // A new cycle may start in the very cycle the grant arrives, so no idle slot
    // is lost on handover, and the owner keeps issuing until asked to let go.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= DCBS_IDLE;
        end else begin
            case (state)
                DCBS_IDLE: begin
                    if (wb_pending) begin
                        state <= DCBS_WB_WAIT;
                    end else if (core_req) begin
                        state <= DCBS_ISSUE;
                    end
                end
                DCBS_ISSUE: begin
                    if (address_strobe) begin
                        state <= DCBS_WAIT;
                    end
                end
                DCBS_WAIT: begin
                    if (bus_done) begin
                        state <= DCBS_IDLE;
                    end
                end
                DCBS_WB_WAIT: begin
                    if (address_strobe) begin
                        state <= DCBS_WB_RUN;
                    end
                end
                DCBS_WB_RUN: begin
                    if (bus_done) begin
                        state <= DCBS_IDLE;
                    end
                end
                default: begin
                    state <= DCBS_IDLE;
                end
            endcase
        end
    end

    // The strobe is combinational so it can rise in the very cycle peer_grant arrives.
    always_comb begin
        address_strobe = 1'b0;
        if ((is_owner || peer_grant) && !give_bus) begin
            address_strobe = want_bus;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bus_addr <= '0;
            bus_write <= 1'b0;
            bus_wb <= 1'b0;
        end else if (state == DCBS_IDLE) begin
            // A snoop writeback is driven exactly as a replacement writeback.
            bus_addr <= wb_pending ? wb_addr : core_addr;
            bus_write <= wb_pending | core_write;
            bus_wb <= wb_pending;
        end
    end

    // ------------------------------------------------------------
    // Snooping.
    // ------------------------------------------------------------
    // The peer may strobe in the very cycle of our grant, so that strobe is snooped too.
    assign snoop_now = pair_enabled && (!is_owner || give_bus) && address_strobe_in;

    always_comb begin
        snoop_match = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < LINES; i++) begin
            if (line_state[i] != DCBS_INVALID && line_tag[i] == snoop_addr) begin
                snoop_match = 1'b1;
                hit_idx = IDX_W'(i);
            end
        end
    end

    // Hit reports are one-cycle pulses on the private two-signal link.
    assign hit_out = snoop_now && snoop_match;
    assign hit_mod_out = hit_out && line_state[hit_idx] == DCBS_MODIFIED;

    // The owed writeback stays pending until it has its own strobe.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wb_pending <= 1'b0;
            wb_addr <= '0;
        end else if (hit_mod_out) begin
            wb_pending <= 1'b1;
            wb_addr <= snoop_addr;
        end else if (state == DCBS_WB_WAIT && address_strobe) begin
            wb_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Line state table.
    // ------------------------------------------------------------
    // One generate entry per line; snoop updates win over fills to the same slot.
    for (genvar g = 0; g < LINES; g++) begin : g_line
        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                line_state[g] <= DCBS_INVALID;
                line_tag[g] <= '0;
            end else if (hit_out && hit_idx == IDX_W'(g)) begin
                // A peer write invalidates, a peer read leaves a shared copy.
                line_state[g] <= write_read_in ? DCBS_INVALID : DCBS_SHARED;
            end else if (fill_line_valid && next_fill_idx == IDX_W'(g)) begin
                line_tag[g] <= fill_tag;
                line_state[g] <= fill_dirty ? DCBS_MODIFIED : DCBS_EXCLUSIVE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            next_fill_idx <= '0;
        end else if (fill_line_valid) begin
            next_fill_idx <= next_fill_idx + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Owner side of a modified hit.
    // ------------------------------------------------------------
    // The flag is set by the peer's report, which comes with our own strobe, and is
    // cleared when the cycle ends.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            drop_cur <= 1'b0;
        end else if ((state == DCBS_ISSUE || state == DCBS_WAIT) && peer_hit_mod) begin
            drop_cur <= 1'b1;
        end else if (state == DCBS_WAIT && bus_done) begin
            drop_cur <= 1'b0;
        end
    end

    assign data_drop = state == DCBS_WAIT && (drop_cur || peer_hit_mod) && bus_data_valid;

    // The dropped cycle is re-run as a plain fill by the core.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rerun <= 1'b0;
            core_ack <= 1'b0;
        end else begin
            rerun <= state == DCBS_WAIT && bus_done && (drop_cur || peer_hit_mod);
            core_ack <= state == DCBS_WAIT && bus_done && !(drop_cur || peer_hit_mod);
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    property p_one_step_swap;
        @(posedge clk_sys) disable iff (!resetn)
        give_bus |=> !is_owner;
    endproperty
    a_one_step_swap: assert property (p_one_step_swap) else $error("owner kept bus");

    property p_req_with_hit;
        @(posedge clk_sys) disable iff (!resetn)
        hit_mod_out |-> req_out && hit_out;
    endproperty
    a_req_with_hit: assert property (p_req_with_hit) else $error("no request on hit");

    property p_no_strobe_unowned;
        @(posedge clk_sys) disable iff (!resetn)
        address_strobe |-> is_owner || peer_grant;
    endproperty
    a_no_strobe_unowned: assert property (p_no_strobe_unowned) else $error("strobe unowned");

    property p_no_grant_busy;
        @(posedge clk_sys) disable iff (!resetn)
        grant_out |-> !outstanding && is_owner;
    endproperty
    a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant while busy");

    property p_grant_soon;
        @(posedge clk_sys) disable iff (!resetn)
        (peer_req_seen && is_owner && state == DCBS_IDLE) |-> grant_out;
    endproperty
    a_grant_soon: assert property (p_grant_soon) else $error("idle owner withheld");

    property p_wb_next;
        @(posedge clk_sys) disable iff (!resetn)
        (wb_pending && state == DCBS_IDLE) |=> state == DCBS_WB_WAIT;
    endproperty
    a_wb_next: assert property (p_wb_next) else $error("writeback not next");

    property p_hit_only_snooper;
        @(posedge clk_sys) disable iff (!resetn)
        hit_out |-> !is_owner || grant_out;
    endproperty
    a_hit_only_snooper: assert property (p_hit_only_snooper) else $error("owner reported hit");

    property p_rerun_after_drop;
        @(posedge clk_sys) disable iff (!resetn)
        (state == DCBS_WAIT && drop_cur && bus_done) |=> rerun && !core_ack;
    endproperty
    a_rerun_after_drop: assert property (p_rerun_after_drop) else $error("no rerun");

    property p_wb_looks_normal;
        @(posedge clk_sys) disable iff (!resetn)
        (state == DCBS_WB_WAIT && address_strobe) |-> bus_wb && bus_write;
    endproperty
    a_wb_looks_normal: assert property (p_wb_looks_normal) else $error("bad writeback");

endmodule

/* dv/dcbs_peer_model.sv */
// Behavioural model of the peer processor that shares the bus with the block.
`timescale 1ns/1ns

module dcbs_peer_model
    import dcbs_pkg::*;
#(
    parameter int TAG_W = DCBS_TAG_W // Line address width.
) (
    input wire logic clk_sys, // Common bus clock, same rate as the block's.
    input wire logic resetn, // Synchronous active-low reset.
    input wire logic cmd_go, // Pulse: run one bus cycle.
    input wire logic [TAG_W-1:0] cmd_addr, // Address of that cycle or modified line.
    input wire logic cmd_write, // That cycle is a write.
    input wire logic mod_set, // Pulse: peer now holds cmd_addr as modified.
    input wire logic [3:0] slow, // Cycles to wait before granting.
    input wire logic address_strobe, // Block's strobe.
    input wire logic [TAG_W-1:0] bus_addr, // Block's address.
    input wire logic req_out, // Block's request.
    input wire logic grant_out, // Block's grant.
    output logic peer_req, // Request to the block.
    output logic peer_grant, // Grant to the block.
    output logic peer_hit, // Snoop hit to the block.
    output logic peer_hit_mod, // Modified snoop hit to the block.
    output logic address_strobe_in, // Peer's strobe.
    output logic [TAG_W-1:0] snoop_addr, // Peer's address.
    output logic write_read_in // Peer's write flag.
);
    logic owner; // Peer holds the bus; secondary starts idle.
    logic pend; // A cycle waits to be issued.
    logic pend_wr; // Write flag of the waiting cycle.
    logic [TAG_W-1:0] pend_addr; // Address of the waiting cycle.
    logic mod_v; // Peer holds a modified line.
    logic [TAG_W-1:0] mod_line; // That line's address.
    logic [2:0] busy; // Cycles left of the peer's own bus cycle.
    logic [3:0] wait_n; // Cycles the block has waited for a grant.
    logic hit_now, s_hit, s_grant, s_req, s_go, s_set, s_wr; // Values sampled at the edge.
    logic [TAG_W-1:0] s_addr; // Sampled command address.

    // A modified hit is reported and the bus requested in the strobe's own cycle.
    assign hit_now = address_strobe && mod_v && (bus_addr == mod_line);
    assign peer_hit = hit_now;
    assign peer_hit_mod = hit_now;
    assign peer_req = (!owner || peer_grant) && (pend || hit_now);

    // Sample at the edge, then change the peer's outputs 1 ns later.
    initial begin
        {owner, pend, pend_wr, mod_v, busy, wait_n} = '0;
        {peer_grant, address_strobe_in, write_read_in, pend_addr, mod_line} = '0;
        snoop_addr = '0;
        forever begin
            @(posedge clk_sys);
            {s_hit, s_grant, s_req, s_go, s_set, s_wr} =
                {hit_now, grant_out, req_out, cmd_go, mod_set, cmd_write};
            s_addr = cmd_addr;
            #1;
            if (peer_grant) owner = 1'b0;
            if (s_grant) owner = 1'b1;
            if (s_hit) begin
                // Writeback owed next; a cmd_go sampled in this cycle or before it issues replaces it.
                {pend, pend_wr, pend_addr, mod_v} = {1'b1, 1'b1, mod_line, 1'b0};
            end
            if (s_go) {pend, pend_wr, pend_addr} = {1'b1, s_wr, s_addr};
            if (s_set) {mod_v, mod_line} = {1'b1, s_addr};
            peer_grant = 1'b0;
            address_strobe_in = 1'b0;
            // Released lines keep moving so a stale value never looks valid.
            snoop_addr = ~snoop_addr;
            write_read_in = ~write_read_in;
            if (busy != 0) busy = busy - 3'h1;
            if (!resetn) begin
                {owner, pend, mod_v, busy, wait_n} = '0;
            end else if (owner && pend && busy == 0) begin
                // Peer keeps the bus for successive cycles while it owns it.
                {address_strobe_in, snoop_addr, write_read_in} = {1'b1, pend_addr, pend_wr};
                {pend, busy} = {1'b0, 3'h2};
            end else if (owner && s_req && busy == 0) begin
                // Grant once the own cycle is over, after a chosen delay.
                if (wait_n >= slow) {peer_grant, wait_n} = {1'b1, 4'h0};
                else wait_n = wait_n + 4'h1;
            end
        end
    end
endmodule

/* dv/dcbs_tb.sv */
// Self-checking testbench for the dual processor bus share and snoop block.
`timescale 1ns/1ns

module dual_cpu_bus_share_and_snoop_tb_top
    import dcbs_pkg::*;
;
    localparam int TW = DCBS_TAG_W; // Line address width.
    logic clk_sys, resetn, core_req, core_write, bus_done, bus_data_valid; // Core and bus side.
    logic fill_line_valid, fill_dirty, cmd_go, cmd_write, mod_set, exp_drop; // Stimulus.
    logic [TW-1:0] core_addr, fill_tag, cmd_addr, snoop_addr, bus_addr, a; // Addresses.
    logic peer_req, peer_grant, peer_hit, peer_hit_mod, address_strobe_in, write_read_in;
    logic address_strobe, bus_write, bus_wb, req_out, grant_out, hit_out, hit_mod_out;
    logic data_drop, rerun, core_ack, is_owner, is_primary, pair_enabled; // Block outputs.
    logic [1:0] lat; // Bus wait states.
    logic [3:0] slow; // Peer grant delay.
    logic [TW+4:0] exp_q[$]; // Expected strobes, acks and reruns, oldest first.
    logic [TW+4:0] act_word; // Observed event of this cycle.
    int fails, tests_run, seed;

    dcbs_share_snoop #(.LINES(DCBS_LINES), .TAG_W(TW)) i_dcbs_share_snoop (
        .clk_sys(clk_sys), .resetn(resetn), .role_select_strap(1'b0), .peer_present(1'b1),
        .core_req(core_req), .core_addr(core_addr), .core_write(core_write), .core_fill(1'b1),
        .bus_done(bus_done), .bus_data_valid(bus_data_valid), .snoop_addr(snoop_addr),
        .address_strobe_in(address_strobe_in), .write_read_in(write_read_in),
        .peer_req(peer_req), .peer_grant(peer_grant), .peer_hit(peer_hit),
        .peer_hit_mod(peer_hit_mod), .fill_line_valid(fill_line_valid), .fill_tag(fill_tag),
        .fill_dirty(fill_dirty), .address_strobe(address_strobe), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_wb(bus_wb), .req_out(req_out), .grant_out(grant_out),
        .hit_out(hit_out), .hit_mod_out(hit_mod_out), .data_drop(data_drop), .rerun(rerun),
        .core_ack(core_ack), .is_owner(is_owner), .is_primary(is_primary),
        .pair_enabled(pair_enabled));

    dcbs_peer_model #(.TAG_W(TW)) i_dcbs_peer_model (
        .clk_sys(clk_sys), .resetn(resetn), .cmd_go(cmd_go), .cmd_addr(cmd_addr),
        .cmd_write(cmd_write), .mod_set(mod_set), .slow(slow), .address_strobe(address_strobe),
        .bus_addr(bus_addr), .req_out(req_out), .grant_out(grant_out), .peer_req(peer_req),
        .peer_grant(peer_grant), .peer_hit(peer_hit), .peer_hit_mod(peer_hit_mod),
        .address_strobe_in(address_strobe_in), .snoop_addr(snoop_addr),
        .write_read_in(write_read_in));

    // ---------------------------------------------------------------
    // Helpers.
    // ---------------------------------------------------------------
    assign act_word = address_strobe ? {3'b100, bus_wb, bus_write, bus_addr}
                                     : {1'b0, core_ack, rerun, 2'b00, {TW{1'b0}}};

    function automatic logic [TW+4:0] ev(input logic [2:0] k, input logic wb, input logic wr,
                                         input logic [TW-1:0] ad);
        return {k, wb, wr, ad};
    endfunction

    task automatic check(input logic [63:0] act, input logic [63:0] exp);
        tests_run++;
        if (act !== exp) begin
            fails++;
            $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One core cycle; a dropped cycle is expected to come back as a rerun.
    task automatic core_op(input logic [TW-1:0] ad, input logic wr, input logic drop);
        exp_q.push_back(ev(3'b100, 1'b0, wr, ad));
        if (drop) exp_q.push_back(ev(3'b001, 1'b0, 1'b0, '0));
        if (drop) exp_q.push_back(ev(3'b100, 1'b0, wr, ad));
        exp_q.push_back(ev(3'b010, 1'b0, 1'b0, '0));
        {exp_drop, core_addr, core_write, core_req} = {drop, ad, wr, 1'b1};
        for (int n = 0; n < 200; n++) begin
            tick(1);
            if (core_ack === 1'b1) break;
            if (rerun === 1'b1) exp_drop = 1'b0;
            core_req = (rerun !== 1'b1);
        end
        core_req = 1'b0;
        tick(1);
    endtask

    // The peer runs one cycle; the block's snoop answer is checked in the strobe cycle.
    task automatic peer_op(input logic [TW-1:0] ad, input logic wr, input logic h, input logic m);
        {cmd_addr, cmd_write, cmd_go} = {ad, wr, 1'b1};
        tick(1);
        cmd_go = 1'b0;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk_sys);
            if (address_strobe_in === 1'b1) break;
        end
        check({address_strobe_in, is_owner, hit_out, hit_mod_out}, {2'b10, h, m});
        check(req_out, m);
        if (m) exp_q.push_back(ev(3'b100, 1'b1, 1'b1, ad));
        tick(12);
    endtask

    // ---------------------------------------------------------------
    // Clock, monitor, bus responder and watchdog.
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Every strobe, ack or rerun must match the oldest note; extra events fail.
    always @(negedge clk_sys) begin
        if (resetn === 1'b1 && (address_strobe === 1'b1 || core_ack === 1'b1 || rerun === 1'b1)) begin
            if (exp_q.size() == 0) check(act_word, '0);
            else check(act_word, exp_q.pop_front());
        end
    end

    // The system ends each block cycle after a few waits; reads return a beat.
    initial begin
        logic wr;
        {bus_done, bus_data_valid} = 2'b00;
        forever begin
            @(negedge clk_sys);
            if (address_strobe === 1'b1) begin
                wr = bus_write;
                repeat (int'(lat) + 1) @(posedge clk_sys);
                #1;
                {bus_done, bus_data_valid} = {1'b1, !wr};
                @(negedge clk_sys);
                if (!wr) check(data_drop, exp_drop);
                tick(1);
                {bus_done, bus_data_valid} = 2'b00;
            end
        end
    end

    // A hang is cut short well after the expected run of a few hundred cycles.
    initial begin
        #100000;
        fails++;
        print_verdict;
    end

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        seed = 99;
        {resetn, core_req, core_write, fill_line_valid, fill_dirty, cmd_go, cmd_write} = '0;
        {mod_set, exp_drop, core_addr, fill_tag, cmd_addr, lat, slow, fails, tests_run} = '0;
        tick(3);
        check({is_owner, is_primary}, 2'b11);
        resetn = 1'b1;
        tick(2);
        check({is_owner, is_primary, pair_enabled}, 3'b111);
        $display("test reset done");
        // Random core cycles; every third one the peer takes the bus first.
        for (int i = 0; i < 9; i++) begin
            a = TW'($random(seed));
            lat = 2'($random(seed));
            slow = 4'($random(seed)) & 4'h3;
            if (i % 3 == 1) peer_op(~a, 1'b0, 1'b0, 1'b0);
            core_op(a, 1'($random(seed)), 1'b0);
        end
        $display("test arbitration done");
        // One modified line snooped by a read, another by a write; a second read checks the state each one is left in.
        for (int w = 0; w < 2; w++) begin
            a = 28'h00ABC00 + TW'(w);
            {fill_tag, fill_dirty, fill_line_valid} = {a, 2'b11};
            tick(1);
            fill_line_valid = 1'b0;
            peer_op(a, w[0], 1'b1, 1'b1);
            peer_op(a, 1'b0, !w[0], 1'b0);
        end
        $display("test snoop writeback done");
        // The peer holds the line modified: the block drops its data and reruns.
        a = TW'($random(seed));
        {cmd_addr, mod_set} = {a, 1'b1};
        tick(1);
        mod_set = 1'b0;
        core_op(a, 1'b0, 1'b1);
        tick(20);
        check(exp_q.size(), 0);
        $display("test dropped fill done");
        print_verdict;
    end
endmodule
